// file: verilog/aref_pkg.sv
// Package of constants, types and helpers for the analog reference block.
//
// Contract
// - Channel one is scaled by 0.0 to 2000.0 percent, 100.0 after reset.
// - Channel two has its own scale of 0.0 to 2000.0 percent, 100.0 default.
// - Channel one holds a signed offset of -500.0 to 500.0 percent, 0.0 default.
// - Channel two holds a signed offset of -500.0 to 500.0 percent, 0.0 default.
// - A positive offset is subtracted from the signal, a negative one added.
// - The offset is a share of full range, so 10.0 percent of 10 V is 1 V.
// - Channel one's format is selectable and resets to 0 to 10 V unipolar.
// - An inverted voltage format maps 10 V to zero and 0 V to full reference.
// - A thermistor format uses channel one as a motor thermistor, not a speed.
// - The tripping 4 to 20 mA variant trips with the loop loss fault on loss.
// - The non-tripping loop variants ramp to stop when current is below 3 mA.
// - An inverted loop format maps 20 mA to zero and 4 mA to full reference.
package aref_pkg;

   localparam int ADC_W = 12;
   localparam int FS = 4096;
   localparam int PCT_ONE = 1000;
   localparam logic [15:0] SCALE_MAX = 16'h4E20;
   localparam logic [15:0] SCALE_RST = 16'h03E8;
   localparam logic signed [15:0] OFFSET_MAX = 16'sh1388;
   localparam logic signed [15:0] OFFSET_MIN = -16'sh1388;
   localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
   localparam logic [15:0] MAX_SPEED_RST = 16'h1388;

   // Loop currents in milliamps; full scale of the converter is 20 mA.
   localparam int LOOP_FULL_MA = 20;
   localparam int LOOP_LOW_MA = 4;
   localparam int LOOP_LOSS_MA = 3;
   localparam logic [11:0] LIVE_ZERO_CODE = 12'(LOOP_LOW_MA * FS / LOOP_FULL_MA);
   localparam logic [11:0] LOSS_CODE = 12'(LOOP_LOSS_MA * FS / LOOP_FULL_MA);
   localparam logic [11:0] CODE_FULL = 12'hFFF;

   typedef enum logic [2:0] {
      FMT_VOLT = 3'h0,
      FMT_VOLT_INV = 3'h1,
      FMT_THERMISTOR = 3'h2,
      FMT_CUR20 = 3'h3,
      FMT_LOOP_TRIP = 3'h4,
      FMT_LOOP_RAMP = 3'h5,
      FMT_LOOP_INV_TRIP = 3'h6,
      FMT_LOOP_INV_RAMP = 3'h7
   } signal_format_t;

   // Register byte addresses.
   localparam logic [7:0] A_CH1_SCALE = 8'h00;
   localparam logic [7:0] A_CH1_OFFSET = 8'h04;
   localparam logic [7:0] A_CH1_FORMAT = 8'h08;
   localparam logic [7:0] A_CH2_SCALE = 8'h0C;
   localparam logic [7:0] A_CH2_OFFSET = 8'h10;
   localparam logic [7:0] A_MAX_SPEED = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam logic [7:0] A_IRQ_CLEAR = 8'h1C;
   localparam logic [7:0] A_IRQ_ENABLE = 8'h20;
   localparam logic [7:0] A_FAULT_CTRL = 8'h24;
   localparam logic [7:0] A_REF1 = 8'h28;
   localparam logic [7:0] A_REF2 = 8'h2C;
   localparam logic [7:0] A_FAULT_INFO = 8'h30;

   // Event bits shared by status, clear and enable.
   localparam int EVT_W = 3;
   localparam int EV_TRIP = 0;
   localparam int EV_RAMP = 1;
   localparam int EV_CLIP = 2;
   localparam int FAULT_RESET_BIT = 0;

   // Values beyond the legal range are pulled to the nearest limit.
   function automatic logic [15:0] clamp_scale(input logic [31:0] v);
      clamp_scale = (v > 32'(SCALE_MAX)) ? SCALE_MAX : v[15:0];
   endfunction : clamp_scale

   function automatic logic signed [15:0] clamp_offset(input logic [31:0] v);
      logic signed [31:0] s;
      s = $signed(v);
      if (s > 32'(OFFSET_MAX)) clamp_offset = OFFSET_MAX;
      else if (s < 32'(OFFSET_MIN)) clamp_offset = OFFSET_MIN;
      else clamp_offset = s[15:0];
   endfunction : clamp_offset

endpackage : aref_pkg

// file: verilog/aref_chan.sv
// One channel path: offset, scaling and saturation to the speed limit.
`timescale 1ns/1ps
`default_nettype none
module aref_chan
   import aref_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [12:0] level_i,
   input wire logic signed [15:0] offset_i,
   input wire logic [15:0] scale_i,
   input wire logic [15:0] max_speed_i,
   output logic [15:0] ref_r,
   output logic clip_r
);

   localparam logic [63:0] DIVISOR = 64'(PCT_ONE) * 64'(FS);

   logic signed [31:0] off_code;
   logic signed [31:0] shifted;
   logic [31:0] shifted_pos;
   logic [63:0] product;
   logic [63:0] quotient;
   logic [15:0] ref_nxt;
   logic clip_nxt;

   // Offset in codes of full range, removed before any scaling, so a large
   // scale magnifies the offset and its own rounding alike.
   always_comb begin
      off_code = ($signed(32'(offset_i)) * FS) / PCT_ONE;
      shifted = $signed({19'h00000, level_i}) - off_code;
      shifted_pos = (shifted < 0) ? 32'h00000000 : shifted;
      product = 64'(shifted_pos) * 64'(scale_i) * 64'(max_speed_i);
      quotient = product / DIVISOR;
      clip_nxt = (quotient > 64'(max_speed_i)) || (shifted < 0);
      ref_nxt = (quotient > 64'(max_speed_i)) ? max_speed_i :
                quotient[15:0];
   end

   // Result register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_r <= 16'h0000;
         clip_r <= 1'b0;
      end else begin
         ref_r <= ref_nxt;
         clip_r <= clip_nxt;
      end
   end

   chk_ref_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> ref_r <= $past(max_speed_i))
      else $error("Channel reference above the speed limit.");

   chk_offset_subtract: assert property (@(posedge clk) disable iff (!rst_n)
      (off_code > $signed({19'h00000, level_i})) |=> ref_r == 16'h0000)
      else $error("Offset larger than signal did not give zero.");

endmodule : aref_chan
`default_nettype wire

// file: verilog/analog_reference_conditioning.sv
// Top of the analog reference conditioning block with its register port.
`timescale 1ns/1ps
`default_nettype none
module analog_reference_conditioning
   import aref_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic [11:0] SAMPLE1,
   input wire logic [11:0] SAMPLE2,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic [15:0] SPEED_REF1,
   output logic [15:0] SPEED_REF2,
   output logic [11:0] THERM_LEVEL,
   output logic THERM_ACTIVE,
   output logic TRIP,
   output logic LOOP_LOSS_FAULT,
   output logic [1:0] FAULT_CHAN,
   output logic RAMP_STOP,
   output logic IRQ
);

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_RAMP = 3'h2,
      ST_TRIP = 3'h4
   } loss_state_t;

   logic rst_meta_r;
   logic rst_n;

   // Reset is released through two stages so every flop leaves it together.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   logic [15:0] scale1_r, scale1_nxt, scale2_r, scale2_nxt;
   logic signed [15:0] offset1_r, offset1_nxt, offset2_r, offset2_nxt;
   signal_format_t fmt_r, fmt_nxt;
   logic [15:0] max_speed_r, max_speed_nxt;
   logic [EVT_W-1:0] status_r, status_nxt, enable_r, enable_nxt;
   logic [EVT_W-1:0] clear_w, event_w;
   logic fault_reset;

   // Register writes; out-of-range scales and offsets are clamped, never wrapped.
   always_comb begin
      scale1_nxt = scale1_r;
      scale2_nxt = scale2_r;
      offset1_nxt = offset1_r;
      offset2_nxt = offset2_r;
      fmt_nxt = fmt_r;
      max_speed_nxt = max_speed_r;
      enable_nxt = enable_r;
      clear_w = '0;
      fault_reset = 1'b0;
      if (WR) begin
         unique case (ADDR)
            A_CH1_SCALE: scale1_nxt = clamp_scale(WDATA);
            A_CH2_SCALE: scale2_nxt = clamp_scale(WDATA);
            A_CH1_OFFSET: offset1_nxt = clamp_offset(WDATA);
            A_CH2_OFFSET: offset2_nxt = clamp_offset(WDATA);
            A_CH1_FORMAT: fmt_nxt = signal_format_t'(WDATA[2:0]);
            A_MAX_SPEED: max_speed_nxt = WDATA[15:0];
            A_IRQ_ENABLE: enable_nxt = WDATA[EVT_W-1:0];
            A_IRQ_CLEAR: clear_w = WDATA[EVT_W-1:0];
            A_FAULT_CTRL: fault_reset = WDATA[FAULT_RESET_BIT];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         scale1_r <= SCALE_RST;
         scale2_r <= SCALE_RST;
         offset1_r <= OFFSET_RST;
         offset2_r <= OFFSET_RST;
         fmt_r <= FMT_VOLT;
         max_speed_r <= MAX_SPEED_RST;
         enable_r <= '0;
      end else begin
         scale1_r <= scale1_nxt;
         scale2_r <= scale2_nxt;
         offset1_r <= offset1_nxt;
         offset2_r <= offset2_nxt;
         fmt_r <= fmt_nxt;
         max_speed_r <= max_speed_nxt;
         enable_r <= enable_nxt;
      end
   end

   logic [11:0] s1_r, s2_r;
   logic [12:0] level1, level2;
   logic is_loop, is_trip_fmt, loss;

   // Maps the raw code to a level where 4096 is full reference.  The live
   // zero span is 0.8 of full scale, so the stretch is d plus d/4, with d the code above the live zero.
   function automatic logic [12:0] stretch(input logic [11:0] x);
      logic [11:0] d;
      d = (x > LIVE_ZERO_CODE) ? (x - LIVE_ZERO_CODE) : 12'h000;
      stretch = {1'b0, d} + {3'h0, d[11:2]};
   endfunction : stretch

   // Samples are registered once so format decode sees stable codes.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 12'h000;
         s2_r <= 12'h000;
      end else begin
         s1_r <= SAMPLE1;
         s2_r <= SAMPLE2;
      end
   end

   // Format decode for channel one; channel two is always a plain level.
   always_comb begin
      level2 = {1'b0, s2_r};
      unique case (fmt_r)
         FMT_VOLT: level1 = {1'b0, s1_r};
         FMT_VOLT_INV: level1 = {1'b0, CODE_FULL - s1_r};
         FMT_THERMISTOR: level1 = 13'h0000;
         FMT_CUR20: level1 = {1'b0, s1_r};
         FMT_LOOP_TRIP, FMT_LOOP_RAMP: level1 = stretch(s1_r);
         FMT_LOOP_INV_TRIP, FMT_LOOP_INV_RAMP: begin
            // Below the live zero the folded code would wrap to a small
            // level, so it is held at full; codes below LOSS_CODE there are a loss.
            level1 = stretch((s1_r < LIVE_ZERO_CODE) ? CODE_FULL :
                  12'(CODE_FULL + LIVE_ZERO_CODE - s1_r));
         end
      endcase
      is_loop = fmt_r[2];
      is_trip_fmt = is_loop && !fmt_r[0];
      loss = is_loop && (s1_r < LOSS_CODE);
   end

   logic [15:0] ref1, ref2;
   logic clip1, clip2;

   aref_chan u_chan1 (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .level_i(level1),
      .offset_i(offset1_r),
      .scale_i(scale1_r),
      .max_speed_i(max_speed_r),
      .ref_r(ref1),
      .clip_r(clip1)
   );

   aref_chan u_chan2 (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .level_i(level2),
      .offset_i(offset2_r),
      .scale_i(scale2_r),
      .max_speed_i(max_speed_r),
      .ref_r(ref2),
      .clip_r(clip2)
   );

   loss_state_t state_r, state_nxt;
   logic [1:0] fault_chan_r, fault_chan_nxt;

   // Loss handling: a trip holds until fault reset, a ramp stop lifts
   // itself once the loop current is back.
   always_comb begin
      state_nxt = state_r;
      fault_chan_nxt = fault_chan_r;
      unique case (state_r)
         ST_RUN: begin
            if (loss && is_trip_fmt) begin
               state_nxt = ST_TRIP;
               fault_chan_nxt = 2'h1;
            end else if (loss) begin
               state_nxt = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (!loss) state_nxt = ST_RUN;
            else if (is_trip_fmt) state_nxt = ST_TRIP;
         end
         ST_TRIP: begin
            if (fault_reset) begin
               state_nxt = ST_RUN;
               fault_chan_nxt = 2'h0;
            end
         end
         default: state_nxt = ST_TRIP;
      endcase
      if (state_nxt == ST_TRIP && state_r != ST_TRIP) fault_chan_nxt = 2'h1;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_RUN;
         fault_chan_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         fault_chan_r <= fault_chan_nxt;
      end
   end

   // Sticky events; a new event beats a clear in the same cycle.
   always_comb begin
      event_w = '0;
      event_w[EV_TRIP] = (state_nxt == ST_TRIP) && (state_r != ST_TRIP);
      event_w[EV_RAMP] = (state_nxt == ST_RAMP) && (state_r != ST_RAMP);
      event_w[EV_CLIP] = clip1 || clip2;
      status_nxt = (status_r & ~clear_w) | event_w;
   end

   logic [31:0] rdata_nxt;
   logic [15:0] out1_nxt;

   // Read mux; unmapped and write-only addresses read as zero.
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (RD) begin
         unique case (ADDR)
            A_CH1_SCALE: rdata_nxt = {16'h0000, scale1_r};
            A_CH2_SCALE: rdata_nxt = {16'h0000, scale2_r};
            A_CH1_OFFSET: rdata_nxt = 32'(offset1_r);
            A_CH2_OFFSET: rdata_nxt = 32'(offset2_r);
            A_CH1_FORMAT: rdata_nxt = {29'h00000000, fmt_r};
            A_MAX_SPEED: rdata_nxt = {16'h0000, max_speed_r};
            A_STATUS: rdata_nxt = {29'h00000000, status_r};
            A_IRQ_ENABLE: rdata_nxt = {29'h00000000, enable_r};
            A_REF1: rdata_nxt = {16'h0000, SPEED_REF1};
            A_REF2: rdata_nxt = {16'h0000, SPEED_REF2};
            A_FAULT_INFO: rdata_nxt = {27'h0000000, state_r, fault_chan_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
      // No speed demand while tripped, ramping or sensing a thermistor.
      out1_nxt = (state_r != ST_RUN || fmt_r == FMT_THERMISTOR) ?
                 16'h0000 : ref1;
   end

   // Output registers, so each pin comes straight from a flop.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= '0;
         RDATA <= 32'h00000000;
         SPEED_REF1 <= 16'h0000;
         SPEED_REF2 <= 16'h0000;
         THERM_LEVEL <= 12'h000;
         THERM_ACTIVE <= 1'b0;
         TRIP <= 1'b0;
         LOOP_LOSS_FAULT <= 1'b0;
         FAULT_CHAN <= 2'h0;
         RAMP_STOP <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         status_r <= status_nxt;
         RDATA <= rdata_nxt;
         SPEED_REF1 <= out1_nxt;
         SPEED_REF2 <= ref2;
         THERM_LEVEL <= (fmt_r == FMT_THERMISTOR) ? s1_r : 12'h000;
         THERM_ACTIVE <= (fmt_r == FMT_THERMISTOR);
         TRIP <= (state_r == ST_TRIP);
         LOOP_LOSS_FAULT <= (state_r == ST_TRIP);
         FAULT_CHAN <= fault_chan_r;
         RAMP_STOP <= (state_r == ST_RAMP);
         IRQ <= |(status_r & enable_r);
      end
   end

   sequence seq_loss_trip;
      state_r == ST_RUN && loss && is_trip_fmt;
   endsequence

   sequence seq_trip_shown;
      state_r == ST_TRIP ##1 (TRIP && LOOP_LOSS_FAULT && FAULT_CHAN == 2'h1);
   endsequence

   chk_loss_trip: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      seq_loss_trip |=> seq_trip_shown)
      else $error("Loop loss did not raise the trip.");

   chk_ramp_stop: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (state_r == ST_RUN && loss && !is_trip_fmt) |=> ##1 RAMP_STOP)
      else $error("Loop loss did not ramp to stop.");

   chk_trip_latch: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (state_r == ST_TRIP && !fault_reset) |=> state_r == ST_TRIP)
      else $error("Trip left without a fault reset.");

   chk_trip_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      TRIP |-> SPEED_REF1 == 16'h0000)
      else $error("Speed demand present while tripped.");

   chk_therm_ref: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (fmt_r == FMT_THERMISTOR) [*2] |=> SPEED_REF1 == 16'h0000 &&
      THERM_ACTIVE)
      else $error("Thermistor format drove a speed demand.");

   chk_scale_clamp: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (WR && ADDR == A_CH1_SCALE && WDATA > 32'(SCALE_MAX))
      |=> scale1_r == SCALE_MAX)
      else $error("Channel one scale not clamped.");

   chk_offset_clamp: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      (WR && ADDR == A_CH2_OFFSET && $signed(WDATA) < 32'(OFFSET_MIN))
      |=> offset2_r == OFFSET_MIN)
      else $error("Channel two offset not clamped.");

   chk_status_sticky: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
      event_w[EV_TRIP] |=> status_r[EV_TRIP])
      else $error("Trip event lost from status.");

endmodule : analog_reference_conditioning
`default_nettype wire

// file: verif/sensor_model.sv
// Behavioural field transmitter that feeds both converter codes.
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
   input wire logic clk,
   input wire logic [11:0] target1,
   input wire logic [11:0] target2,
   input wire logic slow,
   output logic [11:0] code1,
   output logic [11:0] code2
);
   // Both codes start at zero so the converter inputs are never unknown.
   initial begin
      code1 = 12'h000;
      code2 = 12'h000;
   end

   // With slow set, code one slews 64 codes a cycle, so a loop that drifts off takes
   // many cycles to cross the loss level, as a failing transmitter would.
   always @(posedge clk) begin
      code2 <= target2;
      if (!slow || target1 == code1) begin
         code1 <= target1;
      end else if (target1 > code1) begin
         code1 <= (target1 - code1 < 12'h040) ? target1 : code1 + 12'h040;
      end else begin
         code1 <= (code1 - target1 < 12'h040) ? target1 : code1 - 12'h040;
      end
   end
endmodule : sensor_model
`default_nettype wire

// file: verif/analog_reference_conditioning_bench.sv
// Self-checking bench for the analog reference conditioning block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module analog_reference_conditioning_bench;
   import aref_pkg::*;
   logic clk, arst_n, wr, rd, slow, therm_active, trip, loss_fault;
   logic ramp_stop, irq, inv, trips;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rd_val;
   logic [11:0] tgt1, tgt2, s1, s2, therm_level;
   logic [15:0] ref1, ref2;
   logic [1:0] fault_chan;
   int errors = 0;
   int num_checks = 0;
   int f;

   // The free-running system clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   sensor_model u_sensor (.clk(clk), .target1(tgt1), .target2(tgt2),
      .slow(slow), .code1(s1), .code2(s2));

   analog_reference_conditioning u_dut (.CLK_SYS(clk), .ARST_N(arst_n),
      .SAMPLE1(s1), .SAMPLE2(s2), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .SPEED_REF1(ref1), .SPEED_REF2(ref2),
      .THERM_LEVEL(therm_level), .THERM_ACTIVE(therm_active), .TRIP(trip),
      .LOOP_LOSS_FAULT(loss_fault), .FAULT_CHAN(fault_chan),
      .RAMP_STOP(ramp_stop), .IRQ(irq));

   // Expected demand: offset first, then scale, held in 0..max speed.
   function automatic logic [15:0] ref_exp(input int lvl, input int off,
         input int sc);
      longint v;
      longint m;
      m = MAX_SPEED_RST;
      v = lvl - off * FS / PCT_ONE;
      if (v < 0) v = 0;
      v = v * sc * m / (PCT_ONE * FS);
      if (v > m) v = m;
      return 16'(v);
   endfunction : ref_exp

   // Loop level after the live zero is removed and 16 mA spread to full.
   function automatic int loop_lvl(input int code, input logic inv_fmt);
      int c;
      c = inv_fmt ? 4914 - code : code;
      c = (c > 819) ? c - 819 : 0;
      return c + c / 4;
   endfunction : loop_lvl

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      rd_val = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a);
      `CHK(rd_val, e)
   endtask : rd_chk

   // New sensor targets, then time for the three-stage path to settle.
   task automatic drive(input logic [11:0] a, input logic [11:0] b);
      @(posedge clk);
      tgt1 <= a;
      tgt2 <= b;
      slow <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask : drive

   task automatic wait_hi(input logic want_trip);
      int n;
      n = 0;
      while (((want_trip ? trip : ramp_stop) !== 1'b1) && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 100) begin
         errors++;
         give_verdict();
      end
   endtask : wait_hi

   // Main sequence: reset, register limits, path arithmetic, formats.
   initial begin
      arst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      slow = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      tgt1 = 12'h000;
      tgt2 = 12'h000;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(A_CH1_SCALE, 32'h000003E8);
      rd_chk(A_CH2_SCALE, 32'h000003E8);
      rd_chk(A_CH1_OFFSET, 32'h00000000);
      rd_chk(A_CH2_OFFSET, 32'h00000000);
      rd_chk(A_CH1_FORMAT, 32'h00000000);
      rd_chk(A_FAULT_INFO, 32'h00000004);
      rd_chk(8'h40, 32'h00000000);
      wr_reg(A_CH1_SCALE, 32'h00007530);
      rd_chk(A_CH1_SCALE, 32'h00004E20);
      wr_reg(A_CH1_OFFSET, 32'hFFFFE890);
      rd_chk(A_CH1_OFFSET, 32'hFFFFEC78);
      wr_reg(A_CH1_SCALE, 32'h000007D0);
      wr_reg(A_CH1_OFFSET, 32'h00000000);
      wr_reg(A_CH2_SCALE, 32'h000001F4);
      drive(12'h800, 12'hFFF);
      `CHK(ref1, ref_exp(2048, 0, 2000))
      `CHK(ref2, ref_exp(4095, 0, 500))
      wr_reg(A_CH1_SCALE, 32'h000003E8);
      wr_reg(A_CH1_OFFSET, 32'h000000FA);
      wr_reg(A_CH2_OFFSET, 32'hFFFFFF06);
      drive(12'h800, 12'h800);
      `CHK(ref1, ref_exp(2048, 250, 1000))
      `CHK(ref2, ref_exp(2048, -250, 500))
      drive(12'h200, 12'h800);
      `CHK(ref1, 16'h0000)
      rd_reg(A_STATUS);
      `CHK(rd_val[EV_CLIP], 1'b1)
      wr_reg(A_CH1_OFFSET, 32'h00000000);
      wr_reg(A_CH1_FORMAT, 32'(FMT_VOLT_INV));
      drive(12'h400, 12'h800);
      `CHK(ref1, ref_exp(3071, 0, 1000))
      wr_reg(A_CH1_FORMAT, 32'(FMT_THERMISTOR));
      drive(12'h5A5, 12'h800);
      `CHK(therm_active, 1'b1)
      `CHK(therm_level, 12'h5A5)
      wr_reg(A_CH1_FORMAT, 32'(FMT_CUR20));
      drive(12'hFFF, 12'h800);
      `CHK(ref1, ref_exp(4095, 0, 1000))
      `CHK(therm_active, 1'b0)
      // A lower speed limit caps the doubled channel one demand.
      wr_reg(A_MAX_SPEED, 32'h000003E8);
      wr_reg(A_CH1_SCALE, 32'h000007D0);
      drive(12'hFFF, 12'h800);
      `CHK(ref1, 16'h03E8)
      rd_chk(A_MAX_SPEED, 32'h000003E8);
      rd_chk(A_REF1, 32'h000003E8);
      rd_chk(A_REF2, 32'h00000177);
      wr_reg(A_MAX_SPEED, 32'(MAX_SPEED_RST));
      wr_reg(A_CH1_SCALE, 32'h000003E8);
      // Every loop format: scaled level, then a slow drift below 3 mA.
      wr_reg(A_IRQ_ENABLE, 32'h00000001);
      for (f = 4; f < 8; f++) begin
         inv = (f >= 6);
         trips = (f == 4 || f == 6);
         wr_reg(A_CH1_FORMAT, 32'(f));
         drive(inv ? 12'hB32 : 12'h800, 12'h800);
         `CHK(ref1, ref_exp(loop_lvl(2048, 1'b0), 0, 1000))
         @(posedge clk);
         tgt1 <= 12'h1F4;
         slow <= 1'b1;
         wait_hi(trips);
         #20;
         `CHK(trip, trips)
         `CHK(ramp_stop, !trips)
         `CHK(ref1, 16'h0000)
         rd_reg(A_STATUS);
         `CHK(rd_val[EV_TRIP], trips)
         `CHK(rd_val[EV_RAMP], !trips)
         if (trips) begin
            `CHK(loss_fault, 1'b1)
            `CHK(fault_chan, 2'h1)
            rd_chk(A_FAULT_INFO, 32'h00000011);
            `CHK(irq, 1'b1)
            wr_reg(A_IRQ_ENABLE, 32'h00000000);
            repeat (3) @(posedge clk);
            #1;
            `CHK(irq, 1'b0)
            wr_reg(A_IRQ_ENABLE, 32'h00000001);
         end
         drive(inv ? 12'hB32 : 12'h800, 12'h800);
         `CHK(trip, trips)
         `CHK(ramp_stop, 1'b0)
         wr_reg(A_FAULT_CTRL, 32'h00000001);
         wr_reg(A_IRQ_CLEAR, 32'h00000007);
         repeat (4) @(posedge clk);
         #1;
         `CHK(trip, 1'b0)
         `CHK(irq, 1'b0)
      end
      give_verdict();
   end
endmodule : analog_reference_conditioning_bench
`undef CHK
`default_nettype wire
